// File: common/fpdmc_pkg.sv
/*
 Constants, states and timing counts for the fast-page DRAM module controller.
 Assumes a single 10 MHz system clock; all DRAM timing is counted in its cycles.
*/
package fpdmc_pkg;
    localparam int CLK_MHZ = 10;
    localparam int ADDR_W = 20;
    localparam int HALF_W = 10;
    localparam int DATA_W = 8;
    localparam int ROWS = 512;
    localparam int WAKE_CYCLES = 8;
    localparam int POWERUP_US = 100;
    localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
    localparam int REFRESH_MS = 8;
    // One refresh per row interval, rounded down
    localparam int REF_INT_CYC = (REFRESH_MS * 1000 * CLK_MHZ) / ROWS;
    // Per-phase hold in cycles (100 ns each for setup and precharge, 200 ns for access and strobe pulse widths)
    localparam int PRE_CYC = 1;
    localparam int ACC_CYC = 2;
    localparam int RP_CYC = 1;
    localparam logic [15:0] REF_INT_CNT = 16'h0098;
    typedef enum logic [3:0] {
        FPDMC_POWERUP, FPDMC_WAKE_RAS, FPDMC_WAKE_PRE, FPDMC_IDLE, FPDMC_ROW,
        FPDMC_COL, FPDMC_CAS_HI, FPDMC_PRECH, FPDMC_CBR_CAS, FPDMC_CBR_RAS
    } fpdmc_state_e;
endpackage

// File: design/fpdmc_ctrl.sv
/*
 Host-side controller for a 1M x 8 fast-page DRAM module: issues reads, early
 writes, page accesses on the same row, wake-up cycles and column-before-row
 refresh. Assumes the module's data lines are resolved outside from the enable.
*/
`timescale 1ns/1ps
module fpdmc_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [fpdmc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [fpdmc_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rd_valid,
    output logic [fpdmc_pkg::DATA_W-1:0] rd_data,
    output logic init_done,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic write_strobe_n,
    output logic [fpdmc_pkg::HALF_W-1:0] multiplexed_address,
    output logic [fpdmc_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [fpdmc_pkg::DATA_W-1:0] data_lines_in
);
    import fpdmc_pkg::*;

    fpdmc_state_e state_q;
    logic [15:0] tmr_q;
    logic [15:0] ref_cnt_q;
    logic ref_due_q;
    logic [3:0] wake_q;
    logic [HALF_W-1:0] open_row_q;
    logic row_open_q;
    logic wr_q;
    logic [ADDR_W-1:0] addr_q;
    logic tmr_zero;
    logic take;
    logic same_row;
    logic ref_tick;

    assign tmr_zero = (tmr_q == 16'h0000);
    // Last count of the refresh interval; ready drops on this edge
    assign ref_tick = (ref_cnt_q == REF_INT_CNT - 16'h0001);
    assign same_row = row_open_q && (req_addr[ADDR_W-1:HALF_W] == open_row_q);
    // Accept only when refresh is not due
    assign take = req_valid && req_ready && !ref_due_q;

    // Evenly spaced refresh tick, cleared when refresh starts; set wins
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_q <= 16'h0000;
            ref_due_q <= 1'b0;
        end else begin
            if (ref_tick) begin
                ref_cnt_q <= 16'h0000;
                ref_due_q <= 1'b1;
            end else begin
                ref_cnt_q <= ref_cnt_q + 16'h0001;
                if (state_q == FPDMC_CBR_CAS) begin
                    ref_due_q <= 1'b0;
                end
            end
        end
    end

    // Main strobe sequencer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FPDMC_POWERUP;
            tmr_q <= 16'(POWERUP_CYC - 1);
            wake_q <= 4'h0;
            row_strobe_n <= 1'b1;
            col_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            multiplexed_address <= '0;
            data_lines_out <= '0;
            data_lines_oe_n <= 1'b1;
            req_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            init_done <= 1'b0;
            row_open_q <= 1'b0;
            open_row_q <= '0;
            wr_q <= 1'b0;
            addr_q <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (!tmr_zero) begin
                tmr_q <= tmr_q - 16'h0001;
            end
            case (state_q)
                FPDMC_POWERUP: begin
                    if (tmr_zero) begin
                        state_q <= FPDMC_WAKE_RAS;
                        row_strobe_n <= 1'b0;
                        tmr_q <= 16'(ACC_CYC - 1);
                    end
                end
                FPDMC_WAKE_RAS: begin
                    if (tmr_zero) begin
                        row_strobe_n <= 1'b1;
                        wake_q <= wake_q + 4'h1;
                        tmr_q <= 16'(RP_CYC - 1);
                        state_q <= FPDMC_WAKE_PRE;
                    end
                end
                FPDMC_WAKE_PRE: begin
                    if (tmr_zero) begin
                        if (wake_q == 4'(WAKE_CYCLES)) begin
                            state_q <= FPDMC_IDLE;
                            init_done <= 1'b1;
                            req_ready <= !ref_due_q && !ref_tick;
                        end else begin
                            row_strobe_n <= 1'b0;
                            tmr_q <= 16'(ACC_CYC - 1);
                            state_q <= FPDMC_WAKE_RAS;
                        end
                    end
                end
                FPDMC_IDLE: begin
                    // Refresh runs as its own counter cycle, never hidden under a read
                    if (ref_due_q) begin
                        req_ready <= 1'b0;
                        if (row_open_q) begin
                            row_strobe_n <= 1'b1;
                            row_open_q <= 1'b0;
                            tmr_q <= 16'(RP_CYC - 1);
                            state_q <= FPDMC_PRECH;
                        end else begin
                            col_strobe_n <= 1'b0;
                            tmr_q <= 16'(PRE_CYC - 1);
                            state_q <= FPDMC_CBR_CAS;
                        end
                    end else if (take) begin
                        req_ready <= 1'b0;
                        addr_q <= req_addr;
                        wr_q <= req_write;
                        write_strobe_n <= !req_write;
                        data_lines_out <= req_wdata;
                        data_lines_oe_n <= !req_write;
                        if (same_row) begin
                            multiplexed_address <= req_addr[HALF_W-1:0];
                            tmr_q <= 16'(PRE_CYC - 1);
                            state_q <= FPDMC_COL;
                        end else if (row_open_q) begin
                            // Close the old row and go straight on, so refresh cannot drop it
                            row_strobe_n <= 1'b1;
                            row_open_q <= 1'b0;
                            multiplexed_address <= req_addr[ADDR_W-1:HALF_W];
                            tmr_q <= 16'(RP_CYC - 1);
                            state_q <= FPDMC_ROW;
                        end else begin
                            multiplexed_address <= req_addr[ADDR_W-1:HALF_W];
                            tmr_q <= 16'(PRE_CYC - 1);
                            state_q <= FPDMC_ROW;
                        end
                    end else if (ref_tick) begin
                        req_ready <= 1'b0;
                    end
                end
                // Row strobe falls first; the column half follows one cycle later
                FPDMC_ROW: begin
                    if (tmr_zero && row_strobe_n) begin
                        row_strobe_n <= 1'b0;
                        row_open_q <= 1'b1;
                        open_row_q <= addr_q[ADDR_W-1:HALF_W];
                        tmr_q <= 16'(PRE_CYC - 1);
                    end else if (tmr_zero) begin
                        multiplexed_address <= addr_q[HALF_W-1:0];
                        tmr_q <= 16'(PRE_CYC - 1);
                        state_q <= FPDMC_COL;
                    end
                end
                FPDMC_COL: begin
                    if (tmr_zero && col_strobe_n) begin
                        col_strobe_n <= 1'b0;
                        tmr_q <= 16'(ACC_CYC - 1);
                    end else if (tmr_zero) begin
                        col_strobe_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                        data_lines_oe_n <= 1'b1;
                        rd_valid <= !wr_q;
                        rd_data <= data_lines_in;
                        tmr_q <= 16'(PRE_CYC - 1);
                        state_q <= FPDMC_CAS_HI;
                    end
                end
                FPDMC_CAS_HI: begin
                    if (tmr_zero) begin
                        req_ready <= !ref_due_q && !ref_tick;
                        state_q <= FPDMC_IDLE;
                    end
                end
                FPDMC_PRECH: begin
                    if (tmr_zero) begin
                        if (ref_due_q) begin
                            col_strobe_n <= 1'b0;
                            tmr_q <= 16'(PRE_CYC - 1);
                            state_q <= FPDMC_CBR_CAS;
                        end else begin
                            multiplexed_address <= addr_q[ADDR_W-1:HALF_W];
                            state_q <= FPDMC_ROW;
                        end
                    end
                end
                FPDMC_CBR_CAS: begin
                    if (tmr_zero) begin
                        row_strobe_n <= 1'b0;
                        tmr_q <= 16'(ACC_CYC - 1);
                        state_q <= FPDMC_CBR_RAS;
                    end
                end
                FPDMC_CBR_RAS: begin
                    if (tmr_zero) begin
                        row_strobe_n <= 1'b1;
                        col_strobe_n <= 1'b1;
                        tmr_q <= 16'(RP_CYC - 1);
                        state_q <= FPDMC_CAS_HI;
                    end
                end
                default: begin
                    state_q <= FPDMC_IDLE;
                end
            endcase
        end
    end

    a_write_setup_early: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(col_strobe_n) && wr_q && state_q == FPDMC_COL |-> !write_strobe_n)
        else $error("write strobe not low before column strobe");
    a_read_we_high: assert property (@(posedge clock) disable iff (sys_rst)
        !col_strobe_n && !wr_q && state_q == FPDMC_COL |-> write_strobe_n)
        else $error("write strobe low during read");
    a_drive_only_write: assert property (@(posedge clock) disable iff (sys_rst)
        !data_lines_oe_n |-> !write_strobe_n)
        else $error("data driven outside write");
    a_cbr_order: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(row_strobe_n) && state_q == FPDMC_CBR_RAS |-> !col_strobe_n)
        else $error("refresh row strobe without column strobe low");
    a_cas_pulse_len: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(col_strobe_n) && state_q == FPDMC_COL |-> !col_strobe_n [*2])
        else $error("column strobe too short");
    a_cas_precharge: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(col_strobe_n) |=> col_strobe_n)
        else $error("column precharge too short");
    a_cas_under_ras: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(col_strobe_n) && state_q == FPDMC_COL |-> !row_strobe_n)
        else $error("column strobe without open row");
    a_refresh_served: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(ref_due_q) && init_done |-> ##[1:20] state_q == FPDMC_CBR_CAS)
        else $error("refresh not served in time");
    a_wake_count: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(init_done) |-> wake_q == 4'(WAKE_CYCLES))
        else $error("wake-up count wrong");
    a_idle_strobes: assert property (@(posedge clock) disable iff (sys_rst)
        state_q == FPDMC_IDLE && !row_open_q |-> row_strobe_n && col_strobe_n)
        else $error("strobes not high at rest");

    c_read: cover property (@(posedge clock) rd_valid);
    c_write: cover property (@(posedge clock) $fell(col_strobe_n) && wr_q);
    c_refresh: cover property (@(posedge clock) state_q == FPDMC_CBR_RAS);
    c_page: cover property (@(posedge clock) take && same_row);
endmodule // fpdmc_ctrl

// File: verif/fpdmc_dram_model.sv
/*
 Behavioural 1M x 8 fast-page DRAM module, driven only by its strobe edges.
 Assumes the controller's data lines are resolved here from its output enable.
*/
`timescale 1ns/1ps
module fpdmc_dram_model (
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [fpdmc_pkg::HALF_W-1:0] multiplexed_address,
    input wire logic [fpdmc_pkg::DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe_n,
    output logic [fpdmc_pkg::DATA_W-1:0] data_lines_in,
    output int ras_falls,
    output int cbr_count
);
    import fpdmc_pkg::*;
    logic [DATA_W-1:0] mem [int];
    logic [HALF_W-1:0] row_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] last_q;
    logic drive_q;
    initial begin
        ras_falls = 0;
        cbr_count = 0;
        drive_q = 1'b0;
        last_q = 8'h00;
    end
    // Row capture, or counter refresh when the column strobe is already low
    always @(negedge row_strobe_n) begin
        ras_falls = ras_falls + 1;
        if (col_strobe_n) row_q = multiplexed_address;
        else cbr_count = cbr_count + 1;
    end
    // Column capture: early write, or read with access delay
    always @(negedge col_strobe_n) begin
        if (!row_strobe_n) begin
            addr_q = {row_q, multiplexed_address};
            if (!write_strobe_n) mem[addr_q] = data_lines_out;
            else begin
                dout_q = mem.exists(addr_q) ? mem[addr_q] : 8'h00;
                #20 drive_q = ~col_strobe_n;
            end
        end
    end
    // Late write keeps the read data on the lines
    always @(negedge write_strobe_n) begin
        if (!col_strobe_n && !row_strobe_n) mem[addr_q] = data_lines_out;
    end
    // Outputs open whenever the column strobe is high
    always @(posedge col_strobe_n) drive_q = 1'b0;
    // Undriven lines show the inverse of their last level
    assign data_lines_in = !data_lines_oe_n ? data_lines_out : drive_q ? dout_q : ~last_q;
    always @(data_lines_in) begin
        if (!data_lines_oe_n || drive_q) last_q = data_lines_in;
    end
endmodule // fpdmc_dram_model

// File: verif/tb_fpdmc_ctrl.sv
/*
 Self-checking bench for the DRAM controller against the behavioural module.
 Assumes the controller reaches init_done within a few thousand cycles.
*/
`timescale 1ns/1ps
module tb_fpdmc_ctrl;
    import fpdmc_pkg::*;
    logic clock, sys_rst, req_valid, req_write, req_ready, rd_valid, init_done;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata, rd_data, data_lines_out, data_lines_in, rdat;
    logic row_strobe_n, col_strobe_n, write_strobe_n, data_lines_oe_n;
    logic [HALF_W-1:0] multiplexed_address;
    int n_mismatch, n_checks, ras_falls, cbr_count, r0, c0, k;
    logic [ADDR_W-1:0] atab [5] = '{20'h0_0000, 20'hF_FFFF, 20'h0_03FF, 20'hF_FC00, 20'h5_5AAA};
    // Free-running 10 MHz clock
    always #50 clock = ~clock;
    fpdmc_ctrl i_fpdmc_ctrl (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .init_done(init_done),
        .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_strobe_n(write_strobe_n), .multiplexed_address(multiplexed_address),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
        .data_lines_in(data_lines_in));
    fpdmc_dram_model i_fpdmc_dram_model (.row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n),
        .multiplexed_address(multiplexed_address), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in),
        .ras_falls(ras_falls), .cbr_count(cbr_count));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, held until ready is seen at a falling edge
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int i;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clock);
        if (i == 400) begin
            n_mismatch++;
            end_sim();
        end
        @(negedge clock);
        req_valid = 1'b0;
        // Idle edge so the next request never re-raises valid in this step
        @(negedge clock);
    endtask
    task automatic do_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        int i;
        issue(1'b0, a, 8'h00);
        for (i = 0; i < 50 && rd_valid !== 1'b1; i++) @(negedge clock);
        if (i == 50) begin
            n_mismatch++;
            end_sim();
        end
        d = rd_data;
    endtask
    // Wake-up: long pause, then exactly eight row cycles
    task automatic t_init;
        int cyc;
        for (cyc = 0; cyc < 3000 && init_done !== 1'b1; cyc++) @(negedge clock);
        check(init_done, 1);
        check(cyc >= POWERUP_CYC, 1);
        check(ras_falls, WAKE_CYCLES);
    endtask
    // Corner addresses written then read back
    task automatic t_rw;
        for (k = 0; k < 5; k++) issue(1'b1, atab[k], 8'hA0 + 8'(k));
        for (k = 0; k < 5; k++) begin
            do_read(atab[k], rdat);
            check(rdat, 8'hA0 + 8'(k));
        end
    endtask
    // Same-row accesses share one row strobe fall
    task automatic t_page;
        c0 = cbr_count;
        for (k = 0; k < 400 && cbr_count == c0; k++) @(negedge clock);
        check(cbr_count - c0, 1);
        r0 = ras_falls;
        issue(1'b1, 20'h3_1C01, 8'h5A);
        issue(1'b1, 20'h3_1C02, 8'hC3);
        do_read(20'h3_1C01, rdat);
        check(rdat, 8'h5A);
        do_read(20'h3_1C02, rdat);
        check(rdat, 8'hC3);
        check(ras_falls - r0, 1);
    endtask
    // Idle refresh rate, and data kept across counter refresh
    task automatic t_refresh;
        c0 = cbr_count;
        for (k = 0; k < 400 && cbr_count == c0; k++) @(negedge clock);
        check(cbr_count - c0, 1);
        // Window of four and a half intervals after a refresh holds exactly four
        c0 = cbr_count;
        r0 = ras_falls;
        repeat (5 * REF_INT_CNT - REF_INT_CNT / 2) @(negedge clock);
        check(cbr_count - c0, 4);
        check(ras_falls - r0, 4);
        do_read(atab[4], rdat);
        check(rdat, 8'hA4);
    endtask
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 20'h0_0000;
        req_wdata = 8'h00;
        n_mismatch = 0;
        n_checks = 0;
        repeat (10) @(negedge clock);
        check({row_strobe_n, col_strobe_n, write_strobe_n, data_lines_oe_n, init_done}, 5'h1E);
        sys_rst = 1'b0;
        t_init();
        t_rw();
        t_page();
        t_refresh();
        end_sim();
    end
endmodule // tb_fpdmc_ctrl
